// ===== core/dwr_remap.sv
// DRAM window address remap top: strap capture, registered decode, fill tracking
`timescale 1ns/100ps
module dwr_remap
#(
   parameter int GRAN_BITS = 6
)
(
   input  wire logic                        clk_sys,
   input  wire logic                        reset_n,
   input  wire logic [dwr_pkg::SIZE_W-1:0]  dram_size_gb_setting,
   input  wire logic                        swap_variant,
   input  wire logic                        req_valid,
   input  wire logic                        req_write,
   input  wire logic [dwr_pkg::ADDR_W-1:0]  req_addr,
   output logic                             cfg_ready,
   output logic [dwr_pkg::SIZE_W-1:0]       cfg_size_gb,
   output logic                             rsp_valid,
   output logic                             rsp_write,
   output dwr_pkg::dwr_target_e             rsp_target,
   output logic [dwr_pkg::ADDR_W-1:0]       rsp_addr,
   output logic [dwr_pkg::OFF_W-1:0]        rsp_dram_off,
   output logic                             rsp_fill,
   output logic [dwr_pkg::FILL_W-1:0]       rsp_fill_data
);
   localparam int NGRAN = 1 << GRAN_BITS;
   localparam int SETTLE_W = $clog2(dwr_pkg::SYNC_SETTLE + 1);

   dwr_dec_if dec_if ();

   logic [dwr_pkg::SIZE_W-1:0] size_s1_q;
   logic [dwr_pkg::SIZE_W-1:0] size_s2_q;
   logic                       swap_s1_q;
   logic                       swap_s2_q;
   logic                       ready_q;
   logic                       ready_d;
   logic [dwr_pkg::SIZE_W-1:0] size_q;
   logic [dwr_pkg::SIZE_W-1:0] size_d;
   logic                       swap_q;
   logic                       swap_d;
   logic                       vld_q;
   logic                       vld_d;
   logic                       wr_q;
   logic                       wr_d;
   dwr_pkg::dwr_target_e       tgt_q;
   dwr_pkg::dwr_target_e       tgt_d;
   logic [dwr_pkg::ADDR_W-1:0] addr_q;
   logic [dwr_pkg::ADDR_W-1:0] addr_d;
   logic [dwr_pkg::OFF_W-1:0]  off_q;
   logic [dwr_pkg::OFF_W-1:0]  off_d;
   logic                       fill_q;
   logic                       fill_d;
   logic [dwr_pkg::FILL_W-1:0] pat_q;
   logic [NGRAN-1:0]           written_q;
   logic [NGRAN-1:0]           written_d;
   logic [GRAN_BITS-1:0]       gran;
   logic                       take;
   logic [SETTLE_W-1:0]        settle_q;
   logic [SETTLE_W-1:0]        settle_d;
   logic                       settle_done;

   // Straps come from outside the clock domain, so they pass two stages first
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         size_s1_q <= '0;
         size_s2_q <= '0;
         swap_s1_q <= 1'b0;
         swap_s2_q <= 1'b0;
      end
      else
      begin
         size_s1_q <= dram_size_gb_setting;
         size_s2_q <= size_s1_q;
         swap_s1_q <= swap_variant;
         swap_s2_q <= swap_s1_q;
      end
   end

   // Straps may only be captured once the second stage holds the pin level
   assign settle_done = (settle_q == SETTLE_W'(dwr_pkg::SYNC_SETTLE));

   always_comb
   begin
      settle_d = settle_q;
      if (!settle_done)
      begin
         settle_d = settle_q + SETTLE_W'(1);
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         settle_q <= '0;
      end
      else
      begin
         settle_q <= settle_d;
      end
   end

   // Settings are frozen once after reset; a live change would move DRAM under running code
   always_comb
   begin
      ready_d = ready_q;
      size_d  = size_q;
      swap_d  = swap_q;
      if (!ready_q && settle_done)
      begin
         ready_d = 1'b1;
         swap_d  = swap_s2_q;
         // Unsupported sizes fall back to the default rather than leaving DRAM unmapped
         if (size_s2_q == dwr_pkg::SIZE_2GB || size_s2_q == dwr_pkg::SIZE_4GB || size_s2_q == dwr_pkg::SIZE_8GB)
         begin
            size_d = size_s2_q;
         end
         else
         begin
            size_d = dwr_pkg::SIZE_DEFAULT;
         end
      end
   end

   assign dec_if.addr    = req_addr;
   assign dec_if.swap    = swap_q;
   assign dec_if.size_gb = size_q;

   dwr_decode u_decode
   (
      .d (dec_if)
   );

   // Requests before capture are dropped; the straps are not yet known
   assign take = req_valid && ready_q;
   assign gran = dec_if.dram_off[dwr_pkg::OFF_W-1 -: GRAN_BITS];

   // Written-granule tracking: coarse, so a partly written granule no longer reads as fill
   // With the default width all populated DRAM shares one granule; widen GRAN_BITS for finer tracking
   generate
      for (genvar g = 0; g < NGRAN; g++)
      begin : g_written
         always_comb
         begin
            written_d[g] = written_q[g];
            if (take && req_write && dec_if.target == dwr_pkg::DWR_TGT_DRAM && gran == GRAN_BITS'(g))
            begin
               written_d[g] = 1'b1;
            end
         end
      end
   endgenerate

   always_comb
   begin
      vld_d  = take;
      wr_d   = req_write;
      tgt_d  = dec_if.target;
      addr_d = dec_if.phys;
      off_d  = dec_if.dram_off;
      fill_d = take && !req_write && dec_if.target == dwr_pkg::DWR_TGT_DRAM && !written_q[gran];
      if (!take)
      begin
         wr_d   = wr_q;
         tgt_d  = tgt_q;
         addr_d = addr_q;
         off_d  = off_q;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ready_q   <= 1'b0;
         size_q    <= dwr_pkg::SIZE_DEFAULT;
         swap_q    <= 1'b0;
         vld_q     <= 1'b0;
         wr_q      <= 1'b0;
         tgt_q     <= dwr_pkg::DWR_TGT_PERIPH;
         addr_q    <= '0;
         off_q     <= '0;
         fill_q    <= 1'b0;
         pat_q     <= dwr_pkg::FILL_PATTERN;
         written_q <= '0;
      end
      else
      begin
         ready_q   <= ready_d;
         size_q    <= size_d;
         swap_q    <= swap_d;
         vld_q     <= vld_d;
         wr_q      <= wr_d;
         tgt_q     <= tgt_d;
         addr_q    <= addr_d;
         off_q     <= off_d;
         fill_q    <= fill_d;
         pat_q     <= dwr_pkg::FILL_PATTERN;
         written_q <= written_d;
      end
   end

   // Every output is a flop, so the decode path ends at the response registers
   assign cfg_ready     = ready_q;
   assign cfg_size_gb   = size_q;
   assign rsp_valid     = vld_q;
   assign rsp_write     = wr_q;
   assign rsp_target    = tgt_q;
   assign rsp_addr      = addr_q;
   assign rsp_dram_off  = off_q;
   assign rsp_fill      = fill_q;
   assign rsp_fill_data = pat_q;
endmodule : dwr_remap

// ===== core/dwr_pkg.sv
// Constants and types for the DRAM window address remap block
package dwr_pkg;
   localparam int ADDR_W = 40;
   localparam int OFF_W  = 39;
   localparam int SIZE_W = 4;
   localparam int FILL_W = 64;

   // Window bounds in the base map, and the linear DRAM offset each window starts at
   localparam logic [ADDR_W-1:0] W0_BASE = 40'h00_8000_0000;
   localparam logic [ADDR_W-1:0] W0_END  = 40'h00_FFFF_FFFF;
   localparam logic [ADDR_W-1:0] W0_OFF  = 40'h00_0000_0000;
   localparam logic [ADDR_W-1:0] W1_BASE = 40'h08_8000_0000;
   localparam logic [ADDR_W-1:0] W1_END  = 40'h0F_FFFF_FFFF;
   localparam logic [ADDR_W-1:0] W1_OFF  = 40'h00_8000_0000;
   localparam logic [ADDR_W-1:0] W2_BASE = 40'h88_0000_0000;
   localparam logic [ADDR_W-1:0] W2_END  = 40'hFF_FFFF_FFFF;
   localparam logic [ADDR_W-1:0] W2_OFF  = 40'h08_0000_0000;

   // Swap acts on the low 4GB, exchanging its two 2GB halves
   localparam int SWAP_BIT = 31;
   localparam int GB_SHIFT = 30;

   // Edges the strap synchroniser needs before its second stage holds the pin level
   localparam int SYNC_SETTLE = 2;

   localparam logic [SIZE_W-1:0] SIZE_2GB     = 4'h2;
   localparam logic [SIZE_W-1:0] SIZE_4GB     = 4'h4;
   localparam logic [SIZE_W-1:0] SIZE_8GB     = 4'h8;
   localparam logic [SIZE_W-1:0] SIZE_DEFAULT = 4'h4;

   localparam logic [FILL_W-1:0] FILL_PATTERN = 64'hCFDF_DFDF_DFDF_DFDF;

   typedef enum logic [2:0] {
      DWR_TGT_PERIPH = 3'b001,
      DWR_TGT_DRAM   = 3'b010,
      DWR_TGT_NONE   = 3'b100
   } dwr_target_e;
endpackage : dwr_pkg

// ===== core/dwr_dec_if.sv
// Signals between the remap top and its address decoder
`timescale 1ns/100ps
interface dwr_dec_if;
   logic [dwr_pkg::ADDR_W-1:0] addr;
   logic                       swap;
   logic [dwr_pkg::SIZE_W-1:0] size_gb;
   logic [dwr_pkg::ADDR_W-1:0] phys;
   logic [dwr_pkg::OFF_W-1:0]  dram_off;
   dwr_pkg::dwr_target_e       target;

   modport top (output addr, output swap, output size_gb, input phys, input dram_off, input target);
   modport dec (input addr, input swap, input size_gb, output phys, output dram_off, output target);
endinterface : dwr_dec_if

// ===== core/dwr_decode.sv
// Combinational window decoder: swap, window match, linear offset, size check
`timescale 1ns/100ps
module dwr_decode
(
   dwr_dec_if.dec d
);
   logic [dwr_pkg::ADDR_W-1:0] phys;
   logic [dwr_pkg::ADDR_W-1:0] lin;
   logic [dwr_pkg::ADDR_W-1:0] limit;
   logic                       hit;

   always_comb
   begin
      phys = d.addr;
      if (d.swap && (d.addr[dwr_pkg::ADDR_W-1:dwr_pkg::SWAP_BIT+1] == '0))
      begin
         phys[dwr_pkg::SWAP_BIT] = ~d.addr[dwr_pkg::SWAP_BIT];
      end
      hit = 1'b1;
      lin = '0;
      // Windows stack into one linear space, so no two addresses reach one byte
      if (phys >= dwr_pkg::W0_BASE && phys <= dwr_pkg::W0_END)
      begin
         lin = phys - dwr_pkg::W0_BASE + dwr_pkg::W0_OFF;
      end
      else if (phys >= dwr_pkg::W1_BASE && phys <= dwr_pkg::W1_END)
      begin
         lin = phys - dwr_pkg::W1_BASE + dwr_pkg::W1_OFF;
      end
      else if (phys >= dwr_pkg::W2_BASE)
      begin
         lin = phys - dwr_pkg::W2_BASE + dwr_pkg::W2_OFF;
      end
      else
      begin
         hit = 1'b0;
      end
      limit = {{(dwr_pkg::ADDR_W-dwr_pkg::SIZE_W-dwr_pkg::GB_SHIFT){1'b0}}, d.size_gb,
               {dwr_pkg::GB_SHIFT{1'b0}}};
      d.phys     = phys;
      d.dram_off = lin[dwr_pkg::OFF_W-1:0];
      if (!hit)
      begin
         d.target = dwr_pkg::DWR_TGT_PERIPH;
      end
      else if (lin < limit)
      begin
         d.target = dwr_pkg::DWR_TGT_DRAM;
      end
      else
      begin
         d.target = dwr_pkg::DWR_TGT_NONE;
      end
   end
endmodule : dwr_decode

// ===== sim/dwr_remap_props.sv
// Port checker for the DRAM window remap block
`timescale 1ns/100ps
module dwr_remap_props
(
   input wire logic                       clk_sys,
   input wire logic                       reset_n,
   input wire logic [dwr_pkg::SIZE_W-1:0] dram_size_gb_setting,
   input wire logic                       swap_variant,
   input wire logic                       req_valid,
   input wire logic                       req_write,
   input wire logic [dwr_pkg::ADDR_W-1:0] req_addr,
   input wire logic                       cfg_ready,
   input wire logic [dwr_pkg::SIZE_W-1:0] cfg_size_gb,
   input wire logic                       rsp_valid,
   input wire logic                       rsp_write,
   input wire dwr_pkg::dwr_target_e       rsp_target,
   input wire logic [dwr_pkg::ADDR_W-1:0] rsp_addr,
   input wire logic [dwr_pkg::OFF_W-1:0]  rsp_dram_off,
   input wire logic                       rsp_fill,
   input wire logic [dwr_pkg::FILL_W-1:0] rsp_fill_data
);
   wire logic acc;
   assign acc = req_valid & cfg_ready;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   a_rsp_follows_req: assert property (acc |=> rsp_valid)
      else $error("no response after request");
   a_no_extra_rsp: assert property (!acc |=> !rsp_valid)
      else $error("response without request");
   a_high_passthru: assert property (acc && req_addr[39:32] != 8'h00 |=> rsp_addr == $past(req_addr))
      else $error("address above 4GB altered");
   a_half_offset: assert property (acc && req_addr[39:32] == 8'h00 |=> rsp_addr[30:0] == $past(req_addr[30:0]))
      else $error("offset within half lost");
   a_upper_unpop: assert property (acc && req_addr[39] && req_addr[38:35] != 4'h0 |=>
      rsp_target == dwr_pkg::DWR_TGT_NONE && rsp_dram_off == $past(req_addr[38:0]))
      else $error("upper window offset or target wrong");
   a_periph_gap: assert property (acc && !req_addr[39] && req_addr[38:36] != 3'h0 |=>
      rsp_target == dwr_pkg::DWR_TGT_PERIPH) else $error("gap routed to DRAM");
   a_fill_read: assert property (rsp_fill |-> rsp_valid && !rsp_write && rsp_target == dwr_pkg::DWR_TGT_DRAM)
      else $error("fill flag outside DRAM read");
   a_fill_const: assert property (rsp_fill_data == 64'hCFDF_DFDF_DFDF_DFDF)
      else $error("fill pattern wrong");
   a_size_legal: assert property (cfg_size_gb inside {4'h2, 4'h4, 4'h8})
      else $error("captured size not 2, 4 or 8");
   a_dram_size: assert property (rsp_valid && rsp_target == dwr_pkg::DWR_TGT_DRAM |->
      rsp_dram_off < (39'(cfg_size_gb) << 30)) else $error("offset beyond size routed to DRAM");
endmodule : dwr_remap_props
bind dwr_remap dwr_remap_props i_props (.*);

// ===== sim/dwr_master.sv
// Bus master model issuing single address requests
`timescale 1ns/100ps
module dwr_master
(
   input  wire logic              clk_sys,
   output logic                   req_valid,
   output logic                   req_write,
   output logic [dwr_pkg::ADDR_W-1:0] req_addr
);
   initial
   begin
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr  = '0;
   end
   // Released address lines do not keep the last value
   task automatic issue(input logic [39:0] a, input logic wr);
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_write <= wr;
      req_addr  <= a;
      @(posedge clk_sys);
      req_valid <= 1'b0;
      req_addr  <= ~a;
   endtask : issue
endmodule : dwr_master

// ===== sim/dwr_remap_tb.sv
// Self-checking bench for the DRAM window remap block
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module dwr_remap_tb;
   localparam int GB = 6;
   logic        clk_sys, reset_n, swap_variant, req_valid, req_write, cfg_ready, rsp_valid, rsp_write, rsp_fill;
   logic [3:0]  dram_size_gb_setting, cfg_size_gb, size_q;
   logic [39:0] req_addr, rsp_addr;
   logic [38:0] rsp_dram_off;
   logic [63:0] rsp_fill_data;
   logic        swap_q;
   logic        wmap [64];
   dwr_pkg::dwr_target_e rsp_target;
   int          fail_count, cmp_count;
   logic [39:0] corner [10] = '{40'h00_0000_0010, 40'h00_8000_0000, 40'h00_FFFF_FFF8, 40'h08_8000_0000,
      40'h08_FFFF_FFF8, 40'h09_0000_0000, 40'h09_FFFF_FFF8, 40'h0A_0000_0000, 40'h40_0000_0000, 40'h88_0000_0000};
   logic [3:0]  szt [4] = '{4'h2, 4'h4, 4'h8, 4'h5};

   dwr_remap #(.GRAN_BITS(GB)) i_dut (.*);
   dwr_master i_master (.*);

   function automatic void expect_of(input logic [39:0] a, output dwr_pkg::dwr_target_e tg,
      output logic [39:0] ph, output logic [38:0] off);
      logic [39:0] o;
      logic [3:0]  sz;
      logic        dr;
      sz = (size_q inside {4'h2, 4'h4, 4'h8}) ? size_q : 4'h4;
      ph = a;
      if (swap_q && a[39:32] == 8'h00)
         ph[31] = ~a[31];
      dr = 1'b1;
      o = '0;
      if (ph inside {[dwr_pkg::W0_BASE:dwr_pkg::W0_END]})
         o = ph - 40'h00_8000_0000;
      else if (ph inside {[dwr_pkg::W1_BASE:dwr_pkg::W1_END]})
         o = ph - 40'h08_0000_0000;
      else if (ph >= dwr_pkg::W2_BASE)
         o = ph - 40'h80_0000_0000;
      else
         dr = 1'b0;
      off = o[38:0];
      tg = !dr ? dwr_pkg::DWR_TGT_PERIPH : (o < (40'(sz) << 30)) ? dwr_pkg::DWR_TGT_DRAM : dwr_pkg::DWR_TGT_NONE;
   endfunction : expect_of

   task automatic go(input logic [39:0] a, input logic wr);
      dwr_pkg::dwr_target_e tg;
      logic [39:0] ph;
      logic [38:0] off;
      logic        fl;
      expect_of(a, tg, ph, off);
      fl = !wr && tg == dwr_pkg::DWR_TGT_DRAM && !wmap[off[38 -: GB]];
      if (wr && tg == dwr_pkg::DWR_TGT_DRAM)
         wmap[off[38 -: GB]] = 1'b1;
      i_master.issue(a, wr);
      @(negedge clk_sys);
      `CHK("valid", 1'b1, rsp_valid)
      `CHK("target", tg, rsp_target)
      `CHK("phys", ph, rsp_addr)
      if (tg != dwr_pkg::DWR_TGT_PERIPH)
         `CHK("offset", off, rsp_dram_off)
      `CHK("fill", fl, rsp_fill)
      `CHK("write", wr, rsp_write)
      if (fl)
         `CHK("fill data", dwr_pkg::FILL_PATTERN, rsp_fill_data)
   endtask : go

   // Straps are only captured out of reset, so each setting needs its own reset
   task automatic setup(input logic [3:0] sz, input logic sw);
      @(posedge clk_sys);
      dram_size_gb_setting <= sz;
      swap_variant <= sw;
      reset_n <= 1'b0;
      size_q = sz;
      swap_q = sw;
      wmap = '{default: 1'b0};
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      for (int i = 0; i < 8 && cfg_ready !== 1'b1; i++)
         @(posedge clk_sys);
      @(negedge clk_sys);
      `CHK("ready", 1'b1, cfg_ready)
      `CHK("size", (sz inside {4'h2, 4'h4, 4'h8}) ? sz : 4'h4, cfg_size_gb)
   endtask : setup

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : results

   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   initial
   begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      results();
   end

   initial
   begin
      reset_n = 1'b0;
      dram_size_gb_setting = 4'h4;
      swap_variant = 1'b0;
      void'($urandom(32'h02f6));
      for (int c = 0; c < 8; c++)
      begin
         setup(szt[c % 4], c[2]);
         foreach (corner[k])
            go(corner[k], 1'b0);
         go(40'h00_8000_0010, 1'b0);
         go(40'h00_8000_0010, 1'b1);
         go(40'h00_8000_0018, 1'b0);
         repeat (24) go(corner[$urandom % 10] ^ (40'($urandom) & 40'h00_7FFF_FFF8), $urandom % 3 == 0);
      end
      results();
   end
endmodule : dwr_remap_tb
